// [shared/uifr_map.vh]
// Register map, field positions and reset values of the USB interrupt and frame register slice
`ifndef UIFR_MAP_VH
`define UIFR_MAP_VH
`define UIFR_ADDR_W 16
`define UIFR_ADDR_OUT_FLAGS 16'hde04
`define UIFR_ADDR_COM_FLAGS 16'hde06
`define UIFR_ADDR_IN_EN 16'hde07
`define UIFR_ADDR_OUT_EN 16'hde09
`define UIFR_ADDR_COM_EN 16'hde0b
`define UIFR_ADDR_FRAME_LO 16'hde0c
`define UIFR_ADDR_FRAME_HI 16'hde0d
`define UIFR_ADDR_EP_SEL 16'hde0e
`define UIFR_ADDR_IN_MAXP 16'hde10
`define UIFR_OUT_FLAGS_LSB 1
`define UIFR_COM_SOF_BIT 3
`define UIFR_COM_RST_BIT 2
`define UIFR_COM_RES_BIT 1
`define UIFR_COM_SUS_BIT 0
`define UIFR_IN_EN_RST 8'h3f
`define UIFR_OUT_EN_RST 8'h3e
`define UIFR_COM_EN_RST 4'h6
`define UIFR_IN_EN_MASK 8'h3f
`define UIFR_OUT_EN_MASK 8'h3e
`define UIFR_EP_SEL_RST 4'h0
`define UIFR_MAXP_RST 8'h00
`define UIFR_EP_LAST 4'h5
`endif

// [core/uifr_flag_bank.v]
// Clear-on-read sticky flag bank
`timescale 1ns/1ps
`default_nettype none
module uifr_flag_bank #(
  parameter W = 4
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] set,
  input wire clr,
  output reg [W-1:0] flags_q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      // Set wins over the read clear so an event is never dropped
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          flags_q[i] <= 1'b0;
        end else begin
          flags_q[i] <= (flags_q[i] & ~clr) | set[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [core/uifr_regs.v]
// USB interrupt flag, enable, frame number and endpoint index registers
`timescale 1ns/1ps
`default_nettype none
`include "uifr_map.vh"
module uifr_regs #(
  parameter NUM_EP = 5
) (
  input wire clk,
  input wire rst_n,
  input wire [15:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata_q,
  input wire [5:0] in_ep_event_level,
  input wire [NUM_EP-1:0] out_ep_event,
  input wire frame_start_pulse,
  input wire [10:0] frame_number_in,
  input wire bus_reset_pulse,
  input wire bus_resume_pulse,
  input wire bus_suspend_pulse,
  output reg [3:0] endpoint_select_q,
  output reg [7:0] in_max_packet_size_q,
  output reg combined_usb_irq_flag_q
);
  wire rd_out_flags;
  wire rd_com_flags;
  wire [NUM_EP-1:0] out_endpoint_event_flags;
  wire [3:0] common_bus_event_flags;
  wire [3:0] com_set;
  wire [7:0] maxp_rd [0:NUM_EP];
  reg [7:0] in_endpoint_event_enables_q;
  reg [7:0] out_endpoint_event_enables_q;
  reg [3:0] common_bus_event_enables_q;
  reg [10:0] frame_number_q;
  reg [7:0] rdata_d;
  reg [7:0] out_flag_byte;
  reg irq_d;
  wire hit_out_flags;
  wire hit_com_flags;
  wire hit_in_en;
  wire hit_out_en;
  wire hit_com_en;
  wire hit_ep_sel;
  wire hit_maxp;
  wire wr_in_en;
  wire wr_out_en;
  wire wr_com_en;
  wire wr_ep_sel;
  wire wr_maxp;
  wire idx_ok;
  wire irq_out;
  wire irq_com;
  wire irq_in;

  // Exact 16-bit match; a partial decode would alias other register blocks
  assign hit_out_flags = (bus_addr == `UIFR_ADDR_OUT_FLAGS);
  assign hit_com_flags = (bus_addr == `UIFR_ADDR_COM_FLAGS);
  assign hit_in_en = (bus_addr == `UIFR_ADDR_IN_EN);
  assign hit_out_en = (bus_addr == `UIFR_ADDR_OUT_EN);
  assign hit_com_en = (bus_addr == `UIFR_ADDR_COM_EN);
  assign hit_ep_sel = (bus_addr == `UIFR_ADDR_EP_SEL);
  assign hit_maxp = (bus_addr == `UIFR_ADDR_IN_MAXP);
  assign rd_out_flags = bus_rd && hit_out_flags;
  assign rd_com_flags = bus_rd && hit_com_flags;

  // Bus reset wins, so a write landing in its cycle is dropped
  assign wr_in_en = bus_wr && !bus_reset_pulse && hit_in_en;
  assign wr_out_en = bus_wr && !bus_reset_pulse && hit_out_en;
  assign wr_com_en = bus_wr && !bus_reset_pulse && hit_com_en;
  assign wr_ep_sel = bus_wr && !bus_reset_pulse && hit_ep_sel;
  assign wr_maxp = bus_wr && !bus_reset_pulse && hit_maxp;

  // Only endpoints 1 to 5 own a max packet store
  assign idx_ok = (endpoint_select_q != 4'h0) && (endpoint_select_q <= `UIFR_EP_LAST);
  assign com_set = {frame_start_pulse, bus_reset_pulse, bus_resume_pulse, bus_suspend_pulse};

  // Flag and enable pairs feeding the combined interrupt
  // IN flags live outside; only their levels reach the interrupt
  assign irq_out = |(out_flag_byte & out_endpoint_event_enables_q);
  assign irq_com = |(common_bus_event_flags & common_bus_event_enables_q);
  assign irq_in = |(in_ep_event_level & in_endpoint_event_enables_q[5:0]);

  uifr_flag_bank #(.W(NUM_EP)) u_out_flags (
    .clk(clk),
    .rst_n(rst_n),
    .set(out_ep_event),
    .clr(rd_out_flags),
    .flags_q(out_endpoint_event_flags)
  );

  uifr_flag_bank #(.W(4)) u_com_flags (
    .clk(clk),
    .rst_n(rst_n),
    .set(com_set),
    .clr(rd_com_flags),
    .flags_q(common_bus_event_flags)
  );

  // Bus reset beats a software write in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_endpoint_event_enables_q <= `UIFR_IN_EN_RST;
      out_endpoint_event_enables_q <= `UIFR_OUT_EN_RST;
      common_bus_event_enables_q <= `UIFR_COM_EN_RST;
      endpoint_select_q <= `UIFR_EP_SEL_RST;
    end else if (bus_reset_pulse) begin
      in_endpoint_event_enables_q <= in_endpoint_event_enables_q | `UIFR_IN_EN_MASK;
      out_endpoint_event_enables_q <= out_endpoint_event_enables_q | `UIFR_OUT_EN_MASK;
      common_bus_event_enables_q <= `UIFR_COM_EN_RST;
      endpoint_select_q <= `UIFR_EP_SEL_RST;
    end else if (bus_wr) begin
      // Reserved bits 7:6 stay plain storage; software keeps them zero
      if (wr_in_en) begin
        in_endpoint_event_enables_q <= bus_wdata;
      end
      if (wr_out_en) begin
        out_endpoint_event_enables_q <= {bus_wdata[7:1], 1'b0};
      end
      if (wr_com_en) begin
        common_bus_event_enables_q <= bus_wdata[3:0];
      end
      if (wr_ep_sel) begin
        endpoint_select_q <= bus_wdata[3:0];
      end
    end
  end

  // Frame number captured on each start-of-frame
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_number_q <= 11'h000;
    end else if (frame_start_pulse) begin
      frame_number_q <= frame_number_in;
    end
  end

  // One max packet size store per IN endpoint; slot 0 holds nothing
  assign maxp_rd[0] = `UIFR_MAXP_RST;
  genvar e;
  generate
    for (e = 1; e <= NUM_EP; e = e + 1) begin : g_maxp
      localparam [3:0] EP_ID = e;
      reg [7:0] maxp_q;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          maxp_q <= `UIFR_MAXP_RST;
        end else if (wr_maxp && (endpoint_select_q == EP_ID)) begin
          maxp_q <= bus_wdata;
        end
      end
      assign maxp_rd[e] = maxp_q;
    end
  endgenerate

  always @* begin
    out_flag_byte = 8'h00;
    out_flag_byte[`UIFR_OUT_FLAGS_LSB +: NUM_EP] = out_endpoint_event_flags;
    rdata_d = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        `UIFR_ADDR_OUT_FLAGS: rdata_d = out_flag_byte;
        `UIFR_ADDR_COM_FLAGS: rdata_d = {4'h0, common_bus_event_flags};
        `UIFR_ADDR_IN_EN: rdata_d = in_endpoint_event_enables_q;
        `UIFR_ADDR_OUT_EN: rdata_d = out_endpoint_event_enables_q;
        `UIFR_ADDR_COM_EN: rdata_d = {4'h0, common_bus_event_enables_q};
        `UIFR_ADDR_FRAME_LO: rdata_d = frame_number_q[7:0];
        `UIFR_ADDR_FRAME_HI: rdata_d = {5'h00, frame_number_q[10:8]};
        `UIFR_ADDR_EP_SEL: rdata_d = {4'h0, endpoint_select_q};
        `UIFR_ADDR_IN_MAXP: begin
          // Out-of-range index reads zero rather than aliasing
          if (idx_ok) begin
            rdata_d = maxp_rd[endpoint_select_q[2:0]];
          end
        end
        default: rdata_d = 8'h00;
      endcase
    end
    irq_d = irq_out | irq_com | irq_in;
  end

  // Read data holds one cycle, then falls back to zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_q <= 8'h00;
    end else begin
      bus_rdata_q <= rdata_d;
    end
  end

  // Selected size trails the index by one cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_max_packet_size_q <= `UIFR_MAXP_RST;
    end else begin
      in_max_packet_size_q <= idx_ok ? maxp_rd[endpoint_select_q[2:0]] : `UIFR_MAXP_RST;
    end
  end

  // Registered so the interrupt line never glitches on decode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      combined_usb_irq_flag_q <= 1'b0;
    end else begin
      combined_usb_irq_flag_q <= irq_d;
    end
  end
endmodule
`default_nettype wire

// [bench/uifr_host.sv]
// Host model driving token and bus-state events
`timescale 1ns/1ps
`default_nettype none
module uifr_host(
input wire clk,
output wire [4:0] out_ep_event,
output wire frame_start_pulse,
output wire bus_reset_pulse,
output wire bus_resume_pulse,
output wire bus_suspend_pulse,
output logic [10:0] frame_number_in=11'h000);
logic [8:0] k=9'h000;
assign {out_ep_event,frame_start_pulse,bus_reset_pulse,bus_resume_pulse,bus_suspend_pulse}=k;
// Frame field inverted after each event cycle so a stale latch shows
task automatic ev(input logic [8:0] e,input logic [10:0] f);
@(negedge clk);
k=e;
frame_number_in=f;
@(negedge clk);
k=9'h000;
frame_number_in=~f;
endtask
endmodule
`default_nettype wire

// [bench/uifr_regs_assertions.sv]
// Port checker for the USB register slice
`timescale 1ns/1ps
`default_nettype none
module uifr_sva(
input wire clk,rst_n,bus_rd,bus_wr,bus_reset_pulse,combined_usb_irq_flag_q,
input wire [15:0] bus_addr,
input wire [7:0] bus_wdata,bus_rdata_q,in_max_packet_size_q,
input wire [3:0] endpoint_select_q);
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
a_out_spare: assert property(bus_rd&&bus_addr==16'hde04 |=> bus_rdata_q[7:6]==2'b00&&!bus_rdata_q[0])
else $error("out flag spare bit set");
a_com_spare: assert property(bus_rd&&bus_addr==16'hde06 |=> bus_rdata_q[7:4]==4'h0)
else $error("common flag spare bit set");
a_frame_hi: assert property(bus_rd&&bus_addr==16'hde0d |=> bus_rdata_q[7:3]==5'h00)
else $error("frame high spare bit set");
a_idx_rd: assert property(bus_rd&&bus_addr==16'hde0e |=> bus_rdata_q=={4'h0,$past(endpoint_select_q)})
else $error("index read wrong");
a_idx_wr: assert property(bus_wr&&!bus_reset_pulse&&bus_addr==16'hde0e
|=> endpoint_select_q==$past(bus_wdata[3:0])) else $error("index write lost");
a_bus_rst: assert property(bus_reset_pulse |=> endpoint_select_q==4'h0)
else $error("index kept over bus reset");
a_maxp_ep0: assert property(endpoint_select_q==4'h0 |=> in_max_packet_size_q==8'h00)
else $error("max packet nonzero on endpoint 0");
a_rst_irq: assert property(bus_reset_pulse |-> ##2 combined_usb_irq_flag_q)
else $error("no irq after bus reset");
cover property(bus_rd&&bus_addr==16'hde04);
cover property(bus_reset_pulse);
cover property(combined_usb_irq_flag_q);
endmodule
`default_nettype wire

// [bench/usb_irq_frame_index_regs_bench.sv]
// Bench for the USB register slice
`timescale 1ns/1ps
`default_nettype none
module usb_irq_frame_index_regs_bench;
logic clk=0,rst_n=0,bus_rd=0,bus_wr=0,pend=0,combined_usb_irq_flag_q;
logic [15:0] bus_addr=16'h0000;
logic [7:0] bus_wdata=8'h00,bus_rdata_q,in_max_packet_size_q,r,v[6],q[$];
logic [5:0] in_ep_event_level=6'h00;
logic [3:0] endpoint_select_q;
logic [10:0] f,frame_number_in;
wire [4:0] out_ep_event;
wire frame_start_pulse,bus_reset_pulse,bus_resume_pulse,bus_suspend_pulse;
int n_mismatch=0,tests_run=0;
logic [7:0] ra[10]='{8'h04,8'h06,8'h07,8'h09,8'h0b,8'h0c,8'h0d,8'h0e,8'h10,8'h05};
logic [7:0] rv[10]='{8'h00,8'h00,8'h3f,8'h3e,8'h06,8'h00,8'h00,8'h00,8'h00,8'h00};
initial forever #5 clk=~clk;
uifr_host h(.*);
uifr_regs u_dut(.*);
task automatic chk(string n,logic [7:0] e,logic [7:0] g);
tests_run++;
if(g!==e) begin
n_mismatch++;
$display("Error %s expected %h seen %h",n,e,g);
end
endtask
task automatic acc(logic w,logic [7:0] ad,logic [7:0] d);
@(negedge clk);
bus_addr={8'hde,ad};
bus_wdata=d;
{bus_wr,bus_rd}={w,!w};
if(!w) q.push_back(d);
@(negedge clk);
{bus_wr,bus_rd}=2'b00;
endtask
task automatic irqc(logic e);
@(negedge clk);
chk("irq",{7'h00,e},{7'h00,combined_usb_irq_flag_q});
endtask
task automatic summarize;
$display("compares %0d mismatches %0d",tests_run,n_mismatch);
if(n_mismatch==0&&tests_run>0) $display("verification passed");
else $display("verification failed");
$finish;
endtask
always @(posedge clk) begin
if(pend) chk("rdata",q.pop_front(),bus_rdata_q);
pend<=bus_rd;
end
initial begin
repeat(9000) @(posedge clk);
n_mismatch++;
summarize;
end
initial begin
void'($urandom(30676));
repeat(20) @(posedge clk);
@(negedge clk) rst_n=1;
foreach(ra[i]) acc(0,ra[i],rv[i]);
$display("reset values done");
f=11'($urandom);
h.ev(9'h1f0,f);
acc(0,8'h04,8'h3e);
irqc(0);
h.ev(9'h008,f);
irqc(0);
acc(0,8'h06,8'h08);
acc(0,8'h0c,f[7:0]);
acc(0,8'h0d,{5'h00,f[10:8]});
h.ev(9'h002,f);
irqc(1);
acc(0,8'h06,8'h02);
in_ep_event_level=6'h20;
irqc(1);
acc(1,8'h07,8'h00);
irqc(0);
in_ep_event_level=6'h00;
$display("events done");
r=8'($urandom)&8'h3f;
acc(1,8'h07,r);
acc(0,8'h07,r);
acc(1,8'h09,r);
acc(0,8'h09,r&8'h3e);
acc(1,8'h0b,r);
acc(0,8'h0b,r&8'h0f);
v[0]=8'h00;
for(int i=1;i<6;i++) begin
v[i]=8'($urandom);
acc(1,8'h0e,8'(i));
acc(1,8'h10,v[i]);
end
for(int i=0;i<6;i++) begin
acc(1,8'h0e,8'(i));
acc(0,8'h0e,8'(i));
acc(0,8'h10,v[i]);
chk("index",8'(i),{4'h0,endpoint_select_q});
chk("maxp_out",v[i],in_max_packet_size_q);
end
$display("index done");
acc(1,8'h0b,8'h00);
h.ev(9'h004,f);
irqc(1);
acc(0,8'h0e,8'h00);
acc(0,8'h07,8'h3f);
acc(0,8'h0b,8'h06);
acc(0,8'h06,8'h04);
fork
acc(0,8'h06,8'h00);
h.ev(9'h002,f);
join
acc(0,8'h06,8'h02);
$display("bus reset done");
summarize;
end
endmodule
bind uifr_regs uifr_sva c(.*);
`default_nettype wire
